// *** spcl_strap_latch.sv ***
// Strap pin capture and management override of reset defaults
//
// Contract
// - Floating strap reads low, zero default
// - Three straps form address, default zero
// - Straps resampled after every reset event
// - Power-down strap low loads soft power-down
// - Management write of zero leaves power-down
// - Autonegotiation starts when enabled, not powered-down
// - Soft power-down disables most functional modules
// - Role strap: 0 follower, 1 leader
// - Role strap sets both role bits
// - Role bits writable, revert at reset
// - Tx-level strap low gives high ability
// - Tx-level strap high blocks high-level writes
// - Two straps select MAC interface type
// - Media strap counts only in RMII mode
// - Register bit also enables media converter
// - Pins return to normal function after capture; rxd held low in soft power-down
// - Management write or reset re-capture with power-down strap high leaves power-down
`default_nettype none
module spcl_strap_latch (
	input  wire logic                    i_sys_clk,
	input  wire logic                    i_reset_n,
	input  wire logic                    i_soft_reset,
	input  wire logic                    i_addr_strap_bit0,
	input  wire logic                    i_addr_strap_bit1,
	input  wire logic                    i_addr_strap_bit2,
	input  wire logic                    i_powerdown_after_reset_strap,
	input  wire logic                    i_role_pref_strap,
	input  wire logic                    i_tx_level_strap,
	input  wire logic                    i_mac_if_sel_lo_strap,
	input  wire logic                    i_mac_if_sel_hi_strap,
	input  wire logic                    i_media_conv_strap,
	input  wire logic                    i_pin_func_link_up,
	input  wire logic                    i_pin_func_rxd,
	input  wire logic                    i_mgmt_wr,
	input  wire spcl_pkg::spcl_ctrl_t    i_mgmt_wdata,
	output logic                         o_captured,
	output spcl_pkg::spcl_defaults_t     o_defaults,
	output spcl_pkg::spcl_ctrl_t         o_ctrl,
	output logic                         o_media_conv_active,
	output logic                         o_modules_enable,
	output logic                         o_an_start,
	output logic                         o_link_up_indicator,
	output logic                         o_rxd_pin
);
	spcl_pkg::spcl_straps_t  raw_straps;
	spcl_pkg::spcl_straps_t  synced;
	spcl_pkg::spcl_defaults_t next_defaults;
	spcl_pkg::spcl_ctrl_t    next_ctrl;
	logic                    sample_pending;
	logic                    capture_now;
	logic [1:0]              fill;
	logic                    sync_full;
	logic                    tx_locked;
	logic                    wr_tx_hi;
	logic                    rmii_mode;
	logic                    media_active;

	// Pads are pulled low externally/internally; undriven pins arrive as 0
	assign raw_straps = '{
		addr:             {i_addr_strap_bit2, i_addr_strap_bit1, i_addr_strap_bit0},
		pd_after_reset_n: i_powerdown_after_reset_strap,
		role:             i_role_pref_strap,
		tx_level:         i_tx_level_strap,
		mac_hi:           i_mac_if_sel_hi_strap,
		mac_lo:           i_mac_if_sel_lo_strap,
		media_conv:       i_media_conv_strap,
		link_up:          i_pin_func_link_up
	};

	spcl_sync #(
		.WIDTH(spcl_pkg::STRAP_W)
	) u_sync (
		.i_sys_clk(i_sys_clk),
		.i_reset_n(i_reset_n),
		.i_async  (raw_straps),
		.o_sync   (synced)
	);

	// Capture waits until synchroniser has filled after release
	assign sync_full   = (fill == 2'(spcl_pkg::SYNC_STAGES));
	assign capture_now = sample_pending && sync_full && !i_soft_reset;

	assign next_defaults = '{
		phy_addr:               synced.addr,
		high_level_ability_bit: !synced.tx_level,
		mac_if:                 spcl_pkg::spcl_mac_if_t'({synced.mac_hi, synced.mac_lo}),
		media_conv_strap:       synced.media_conv
	};

	assign tx_locked = !o_defaults.high_level_ability_bit;
	assign wr_tx_hi  = tx_locked ? 1'h0 : i_mgmt_wdata.tx_hi_level_en;

	always_comb begin
		next_ctrl = o_ctrl;
		if (capture_now) begin
			next_ctrl.adv_role_leader_bit    = synced.role;
			next_ctrl.forced_role_leader_bit = synced.role;
			next_ctrl.soft_powerdown_ctrl    = !synced.pd_after_reset_n;
			next_ctrl.tx_hi_level_en         = spcl_pkg::TX_HI_RESET;
			next_ctrl.media_conv_enable      = spcl_pkg::MEDIA_RESET;
			next_ctrl.an_enable              = spcl_pkg::AN_EN_RESET;
		end else if (i_mgmt_wr && o_captured) begin
			next_ctrl                = i_mgmt_wdata;
			next_ctrl.tx_hi_level_en = wr_tx_hi;
		end
	end

	assign rmii_mode    = (o_defaults.mac_if == spcl_pkg::SPCL_MAC_RMII);
	// Register enable is an alternative to the strap
	assign media_active = rmii_mode && o_defaults.media_conv_strap
		|| next_ctrl.media_conv_enable;

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			sample_pending <= 1'h1;
			o_captured     <= 1'h0;
		end else if (i_soft_reset) begin
			sample_pending <= 1'h1;
			o_captured     <= 1'h0;
		end else begin
			sample_pending <= sample_pending && !capture_now;
			o_captured     <= o_captured || capture_now;
		end
	end

	// Synchroniser is cleared by hard reset; wait until it holds pin levels
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			fill <= 2'h0;
		end else if (!sync_full) begin
			fill <= fill + 2'h1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			o_defaults <= '{
				phy_addr:               spcl_pkg::ADDR_RESET,
				high_level_ability_bit: spcl_pkg::HI_ABLE_RESET,
				mac_if:                 spcl_pkg::SPCL_MAC_RMII,
				media_conv_strap:       spcl_pkg::MEDIA_RESET
			};
		end else if (capture_now) begin
			o_defaults <= next_defaults;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			o_ctrl <= '{
				adv_role_leader_bit:    spcl_pkg::ROLE_RESET,
				forced_role_leader_bit: spcl_pkg::ROLE_RESET,
				soft_powerdown_ctrl:    spcl_pkg::PD_RESET,
				tx_hi_level_en:         spcl_pkg::TX_HI_RESET,
				media_conv_enable:      spcl_pkg::MEDIA_RESET,
				an_enable:              spcl_pkg::AN_EN_RESET
			};
		end else begin
			o_ctrl <= next_ctrl;
		end
	end

	// Power-down gates modules; AN starts only when enabled and powered up
	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			o_modules_enable    <= 1'h0;
			o_an_start          <= 1'h0;
			o_media_conv_active <= 1'h0;
			o_link_up_indicator <= 1'h0;
			o_rxd_pin           <= 1'h0;
		end else begin
			o_modules_enable    <= o_captured && !next_ctrl.soft_powerdown_ctrl;
			o_an_start          <= o_captured && next_ctrl.an_enable
				&& !next_ctrl.soft_powerdown_ctrl;
			o_media_conv_active <= o_captured && media_active;
			// Shared pins drive normal function only after capture
			o_link_up_indicator <= o_captured && !i_soft_reset && synced.link_up;
			o_rxd_pin           <= o_captured && !i_soft_reset && !next_ctrl.soft_powerdown_ctrl
				&& i_pin_func_rxd;
		end
	end
endmodule // spcl_strap_latch
`default_nettype wire

// *** spcl_pkg.sv ***
// Package: strap latch constants, modes and carrier structs
`default_nettype none
package spcl_pkg;
	localparam int          ADDR_W         = 3;
	localparam logic [2:0]  ADDR_RESET     = 3'h0;
	localparam logic        PD_RESET       = 1'h1;
	localparam logic        ROLE_RESET     = 1'h0;
	localparam logic        HI_ABLE_RESET  = 1'h1;
	localparam logic        MEDIA_RESET    = 1'h0;
	localparam logic        AN_EN_RESET    = 1'h1;
	localparam logic        TX_HI_RESET    = 1'h0;
	localparam int          SYNC_STAGES    = 2;
	localparam int          STRAP_W        = 10;

	typedef enum logic [1:0] {
		SPCL_MAC_RMII,
		SPCL_MAC_RGMII,
		SPCL_MAC_RSVD,
		SPCL_MAC_MII
	} spcl_mac_if_t;

	typedef struct packed {
		logic [2:0] addr;
		logic       pd_after_reset_n;
		logic       role;
		logic       tx_level;
		logic       mac_hi;
		logic       mac_lo;
		logic       media_conv;
		logic       link_up;
	} spcl_straps_t;

	typedef struct packed {
		logic [2:0]   phy_addr;
		logic         high_level_ability_bit;
		spcl_mac_if_t mac_if;
		logic         media_conv_strap;
	} spcl_defaults_t;

	typedef struct packed {
		logic adv_role_leader_bit;
		logic forced_role_leader_bit;
		logic soft_powerdown_ctrl;
		logic tx_hi_level_en;
		logic media_conv_enable;
		logic an_enable;
	} spcl_ctrl_t;
endpackage : spcl_pkg
`default_nettype wire

// *** spcl_sync.sv ***
// Two-flop synchroniser for a vector of pin levels
`default_nettype none
module spcl_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_reset_n,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			meta   <= '0;
			o_sync <= '0;
		end else begin
			meta   <= i_async;
			o_sync <= meta;
		end
	end
endmodule // spcl_sync
`default_nettype wire

// *** spcl_strap_pins.sv ***
// Partner model: host outputs and pull-downs behind the strap pins
`default_nettype none
module spcl_strap_pins (
	input  wire spcl_pkg::spcl_straps_t i_gpio_en,
	input  wire spcl_pkg::spcl_straps_t i_gpio_level,
	output spcl_pkg::spcl_straps_t      o_pins
);
	timeunit 1ns;
	timeprecision 1ps;
	// Released pins sink to the pull-down level
	assign o_pins = i_gpio_en & i_gpio_level;
endmodule // spcl_strap_pins
`default_nettype wire

// *** spcl_strap_latch_asserts.sv ***
// Port-level assertions for the strap latch
`default_nettype none
module spcl_strap_latch_asserts (
	input wire logic                     i_sys_clk,
	input wire logic                     i_reset_n,
	input wire logic                     i_soft_reset,
	input wire logic                     i_addr_strap_bit0,
	input wire logic                     i_addr_strap_bit1,
	input wire logic                     i_addr_strap_bit2,
	input wire logic                     i_powerdown_after_reset_strap,
	input wire logic                     i_role_pref_strap,
	input wire logic                     i_mgmt_wr,
	input wire spcl_pkg::spcl_ctrl_t     i_mgmt_wdata,
	input wire logic                     o_captured,
	input wire spcl_pkg::spcl_defaults_t o_defaults,
	input wire spcl_pkg::spcl_ctrl_t     o_ctrl,
	input wire logic                     o_media_conv_active,
	input wire logic                     o_modules_enable,
	input wire logic                     o_an_start,
	input wire logic                     o_link_up_indicator,
	input wire logic                     o_rxd_pin
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_calm; (o_captured && !i_soft_reset) [*3]; endsequence
	a_addr_load: assert property ($rose(o_captured) |-> o_defaults.phy_addr ==
		{i_addr_strap_bit2, i_addr_strap_bit1, i_addr_strap_bit0}) else $error("bad address");
	a_pd_load: assert property ($rose(o_captured) |->
		o_ctrl.soft_powerdown_ctrl == !i_powerdown_after_reset_strap) else $error("bad pd");
	a_role_load: assert property ($rose(o_captured) |-> o_ctrl.adv_role_leader_bit ==
		i_role_pref_strap && o_ctrl.forced_role_leader_bit == i_role_pref_strap)
		else $error("bad role");
	a_hold_defaults: assert property (s_calm |=> $stable(o_defaults))
		else $error("defaults moved");
	a_tx_blocked: assert property (!o_defaults.high_level_ability_bit |->
		!o_ctrl.tx_hi_level_en) else $error("tx level set");
	a_write_taken: assert property (i_mgmt_wr && o_captured && !i_soft_reset &&
		o_defaults.high_level_ability_bit |=> o_ctrl == $past(i_mgmt_wdata)) else $error("lost write");
	a_power_gate: assert property (s_calm |-> o_modules_enable == !o_ctrl.soft_powerdown_ctrl &&
		o_an_start == (o_modules_enable && o_ctrl.an_enable)) else $error("bad gating");
	a_media_mode: assert property (s_calm |-> o_media_conv_active == (o_ctrl.media_conv_enable ||
		o_defaults.mac_if == spcl_pkg::SPCL_MAC_RMII && o_defaults.media_conv_strap))
		else $error("bad media");
	a_pins_quiet: assert property (!o_captured |-> !o_link_up_indicator && !o_rxd_pin)
		else $error("pin early");
endmodule // spcl_strap_latch_asserts
bind spcl_strap_latch spcl_strap_latch_asserts u_chk (.i_sys_clk, .i_reset_n, .i_soft_reset,
	.i_addr_strap_bit0, .i_addr_strap_bit1, .i_addr_strap_bit2, .i_powerdown_after_reset_strap,
	.i_role_pref_strap, .i_mgmt_wr, .i_mgmt_wdata, .o_captured, .o_defaults, .o_ctrl,
	.o_media_conv_active, .o_modules_enable, .o_an_start, .o_link_up_indicator, .o_rxd_pin);
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the strap latch
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("BAD t=%0t got %h exp %h", $time, a, e); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk = 1'h0, i_reset_n = 1'h0, i_soft_reset = 1'h0, i_mgmt_wr = 1'h0;
	logic o_captured, o_media_conv_active, o_modules_enable, o_an_start, o_link_up_indicator, o_rxd_pin;
	spcl_pkg::spcl_ctrl_t     i_mgmt_wdata = '0, o_ctrl;
	spcl_pkg::spcl_defaults_t o_defaults;
	spcl_pkg::spcl_straps_t   gpio_en = '0, pins;
	int                       bad_count, total_checks, tests;
	// Driven straps in [23:14], expected defaults, control and media state below
	localparam logic [23:0] ROWS [4] = '{24'h000412, 24'hBBAFE2, 24'h439792, 24'hF0BC83};
	spcl_strap_pins MODEL (.i_gpio_en(gpio_en), .i_gpio_level('1), .o_pins(pins));
	spcl_strap_latch DUT (.i_sys_clk, .i_reset_n, .i_soft_reset, .i_addr_strap_bit0(pins.addr[0]),
		.i_addr_strap_bit1(pins.addr[1]), .i_addr_strap_bit2(pins.addr[2]),
		.i_powerdown_after_reset_strap(pins.pd_after_reset_n), .i_role_pref_strap(pins.role),
		.i_tx_level_strap(pins.tx_level), .i_mac_if_sel_lo_strap(pins.mac_lo),
		.i_mac_if_sel_hi_strap(pins.mac_hi), .i_media_conv_strap(pins.media_conv),
		.i_pin_func_link_up(pins.link_up), .i_pin_func_rxd(1'h1), .i_mgmt_wr, .i_mgmt_wdata,
		.o_captured, .o_defaults, .o_ctrl, .o_media_conv_active, .o_modules_enable, .o_an_start,
		.o_link_up_indicator, .o_rxd_pin);
	initial begin
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask
	// Straps held from reset entry until well after release
	task automatic boot(input logic [9:0] s, input logic hard);
		gpio_en <= spcl_pkg::spcl_straps_t'(s);
		if (hard) i_reset_n <= 1'h0;
		else i_soft_reset <= 1'h1;
		cyc(4);
		i_reset_n <= 1'h1;
		i_soft_reset <= 1'h0;
		cyc(6);
	endtask
	task automatic wr(input logic [5:0] w);
		i_mgmt_wr <= 1'h1;
		i_mgmt_wdata <= spcl_pkg::spcl_ctrl_t'(w);
		cyc(1);
		i_mgmt_wr <= 1'h0;
		cyc(1);
	endtask
	task automatic fin();
		tests++;
		$display("test %0d ended", tests);
	endtask
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		cyc(2000);
		bad_count++;
		wrap_up();
	end
	initial begin
		cyc(20);
		i_reset_n <= 1'h1;
		cyc(6);
		for (int k = 0; k < 4; k++) begin
			boot(ROWS[k][23:14], 1'h0);
			`CHK({o_defaults, o_ctrl, o_media_conv_active}, ROWS[k][13:0])
			fin();
		end
		boot(10'h2FE, 1'h0);
		wr(6'h3F);
		`CHK({o_ctrl, o_modules_enable, o_an_start, o_media_conv_active}, 9'h1D9)
		wr(6'h21);
		`CHK({o_ctrl, o_modules_enable, o_an_start, o_media_conv_active}, 9'h10E)
		boot(10'h2EE, 1'h0);
		`CHK({o_ctrl, o_modules_enable, o_an_start, o_media_conv_active}, 9'h18E)
		`CHK({o_link_up_indicator, o_rxd_pin}, 2'h1)
		fin();
		boot(10'h000, 1'h1);
		`CHK({o_defaults, o_ctrl, o_media_conv_active}, 14'h0412)
		fin();
		wrap_up();
	end
endmodule // tb
`default_nettype wire
